// ==== src/pidc_ctrl.sv ====
// Page interleave DRAM controller: cycle decode, DRAM/ROM timing, shadow, remap, refresh, port 92.
// Assumes processor strobes share core_clk_i; refresh, bus ready and keyboard gate are asynchronous pins.
// Contract
// - Page hit wait states programmable 0 to 3
// - Page miss wait states programmable 1 to 4
// - Optional one fewer wait on write miss
// - A miss always gets one wait minimum
// - RAS precharge 2 to 5 clocks
// - CAS start separate for hit, read/write miss
// - Row to column switch in half clocks
// - ROM select range in 16K steps
// - ROM wait states 1 to 10
// - Shadow any 16K segment A0000-FFFFF
// - Per-segment write protect blocks RAM writes
// - Local 0-640K disableable in 128K blocks
// - Disabled local memory goes to system bus
// - Eight remap choices, full remap kills shadow
// - Two- or four-way interleave, switchable
// - Staggered refresh RAS offsets per bank
// - Pipelined mode uses next-address output
// - Port 92 fast A20 gate and reset
`timescale 1ns/1ps
module pidc_ctrl import pidc_pkg::*; (
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  input  wire logic        cpu_ads_i,
  input  wire logic [23:1] cpu_adr_i,
  input  wire logic        cpu_wr_i,
  input  wire logic        cpu_mio_i,
  input  wire logic [7:0]  cpu_wdata_i,
  output logic             cpu_rdy_o,
  output logic             cpu_na_o,
  output logic      [7:0]  cpu_iodata_o,
  output logic             cpu_reset_o,
  input  wire logic        a20_kbd_i,
  output logic             address_bit20_gate_o,
  input  wire logic        refresh_req_i,
  input  wire logic        sysbus_rdy_i,
  output logic             sysbus_fwd_o,
  output logic             rom_cs_n_o,
  output logic      [3:0]  ras_n_o,
  output logic      [3:0]  cas_n_o,
  output logic      [10:0] dram_ma_o,
  output logic             dram_we_n_o
);
  pidc_state_t st_r, st_nxt;
  logic [31:0] cfg_r, cas_cfg_r, romws_r, romlo_r, romhi_r, shen_r, shwp_r, map_r;
  logic [2:0]  ref_s_r, bus_s_r, kbd_s_r;
  logic        ads_pend_r, p92_a20_r, last_hit_r, neg_sel_r, ma_col_r;
  logic [7:0]  rst_cnt_r;
  logic [5:0]  cnt_r, len_r, cas_at_r;
  logic [3:0]  col_at_r, open_r, ref_ras_r;
  logic [1:0]  bank_r;
  logic        wr_r, wp_r, hit_r;
  logic [23:1] adr_r;
  logic [ROW_W-1:0] row_r, tag_q;
  logic [9:0]  col_r;

  // Pins from outside the clock domain; only stage 1 reads stage 0
  always_ff @(posedge core_clk_i) begin
    ref_s_r <= {ref_s_r[1:0], refresh_req_i};
    bus_s_r <= {bus_s_r[1:0], sysbus_rdy_i};
    kbd_s_r <= {kbd_s_r[1:0], a20_kbd_i};
  end
  wire ref_req = ref_s_r[1];
  wire bus_rdy = bus_s_r[1];
  wire a20_en  = p92_a20_r | kbd_s_r[1];

  // Configuration fields
  wire [1:0] hit_ws  = cfg_r[F_HIT +: 2];
  wire [1:0] miss_cd = cfg_r[F_MISS +: 2];
  wire       wr_less = cfg_r[F_WRL];
  wire [2:0] pre_clk = {1'b0, cfg_r[F_PRE +: 2]} + 3'h2;
  wire [1:0] ilv     = cfg_r[F_ILV +: 2];
  wire       pipe    = cfg_r[F_PIPE];
  wire       stag    = cfg_r[F_STAG];
  wire [4:0] dis     = map_r[F_DIS +: 5];
  wire [2:0] rmap    = map_r[F_RMAP +: 3];

  // Address decode on the latched cycle
  wire [23:0] a_w     = {adr_r[23:21], adr_r[20] & a20_en, adr_r[19:1], 1'b0};
  wire        in_low  = a_w < SH_BASE;
  wire [2:0]  low_blk = a_w[BLK_SH +: 3];
  wire        low_dis = dis[low_blk] | ((rmap == RMAP_SPLIT) & (a_w >= SPLIT_BASE));
  wire        in_sh   = (a_w >= SH_BASE) & (a_w < ONE_MEG);
  wire [23:0] sh_off  = a_w - SH_BASE;
  wire [4:0]  seg     = sh_off[SEG_SH +: 5];
  wire        sh_on   = shen_r[seg] & (rmap != RMAP_FULL);
  wire [23:0] rsize   = remap_size(rmap);
  wire        in_rel  = (a_w >= DRAM_TOP) & (a_w < DRAM_TOP + rsize);
  wire        in_hi   = (a_w >= ONE_MEG) & (a_w < DRAM_TOP);
  wire [9:0]  a_blk   = a_w[23:SEG_SH];
  wire        rom_hit = (a_blk >= romlo_r[9:0]) & (a_blk <= romhi_r[9:0]);
  logic       cpu_mio_i_l;
  wire        io92    = ~cpu_mio_i_l & (adr_r == P92_WADR);
  wire        dram_sel = cpu_mio_i_l & ((in_low & ~low_dis) | (in_sh & sh_on) | in_hi | in_rel);
  wire        rom_sel  = cpu_mio_i_l & ~dram_sel & rom_hit;
  wire [23:0] rel_base = (rmap == RMAP_SPLIT) ? SPLIT_BASE : SH_BASE;
  wire [23:0] phys     = in_rel ? rel_base + (a_w - DRAM_TOP) : a_w;

  // Bank selection per interleave mode
  wire [1:0] bank_w = (ilv == ILV_FOUR) ? phys[12:11] :
                      (ilv == ILV_TWO)  ? {phys[22], phys[11]} : phys[22:21];
  wire [ROW_W-1:0] row_w = phys[22:11];
  wire       hit_w  = open_r[bank_w] & (tag_q == row_w);

  // Wait-state arithmetic, one wait state is one processor state
  wire [2:0] miss_raw = {1'b0, miss_cd} + 3'h1;
  wire [2:0] miss_wr  = (wr_r & wr_less) ? miss_raw - 3'h1 : miss_raw;
  wire [2:0] miss_ws  = (miss_wr == 3'h0) ? 3'h1 : miss_wr;
  wire [3:0] rom_ws   = (romws_r[3:0] < ROM_WS_MIN) ? ROM_WS_MIN :
                        (romws_r[3:0] > ROM_WS_MAX) ? ROM_WS_MAX : romws_r[3:0];
  wire [5:0] hit_len  = 6'(T_CLKS * (2 + hit_ws));
  wire [5:0] miss_len = 6'(T_CLKS * (2 + miss_ws));
  wire [5:0] rom_len  = 6'(T_CLKS * (2 + rom_ws));
  wire [1:0] cas_cd   = hit_w ? cas_cfg_r[F_CH +: 2] :
                        wr_r  ? cas_cfg_r[F_CW +: 2] : cas_cfg_r[F_CR +: 2];
  wire [5:0] cas_w    = 6'(T_CLKS) + {4'h0, cas_cd};
  // Clamp against the length of this access, not the one latched before it
  wire [5:0] acc_len  = hit_w ? hit_len : miss_len;

  // Cycle counter conditions
  wire       last    = (cnt_r == len_r - 6'h1);
  wire [5:0] pre_end = {3'h0, pre_clk} - 6'h1;
  wire [5:0] ref_end = 6'({3'h0, pre_clk} + REF_RAS_CLKS + 3 * STAG_CLKS);
  wire       go      = cpu_ads_i | ads_pend_r;

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_IDLE: if (go) st_nxt = ST_DEC;
               else if (ref_req) st_nxt = ST_REF;
      ST_DEC:  st_nxt = io92 ? ST_IO : dram_sel ? ST_TAG : rom_sel ? ST_ROM : ST_BUS;
      ST_TAG:  st_nxt = hit_w ? ST_ACC : ST_PRE;
      ST_PRE:  if (cnt_r == pre_end) st_nxt = ST_ACC;
      ST_ACC:  if (last) st_nxt = ST_IDLE;
      ST_ROM:  if (last) st_nxt = ST_IDLE;
      ST_BUS:  if (bus_rdy) st_nxt = ST_IDLE;
      ST_IO:   st_nxt = ST_IDLE;
      ST_REF:  if (cnt_r == ref_end) st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      st_r <= ST_IDLE;
      cnt_r <= 6'h00;
    end else begin
      st_r <= st_nxt;
      cnt_r <= (st_nxt != st_r) ? 6'h00 : cnt_r + 6'h01;
    end
  end

  // A strobe seen while refreshing waits for the refresh to end
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) ads_pend_r <= 1'b0;
    else if (cpu_ads_i && st_r != ST_IDLE) ads_pend_r <= 1'b1;
    else if (st_r == ST_IDLE) ads_pend_r <= 1'b0;
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      adr_r <= 23'h000000;
      wr_r <= 1'b0;
      cpu_mio_i_l <= 1'b0;
    end else if (st_r == ST_IDLE && cpu_ads_i) begin
      adr_r <= cpu_adr_i;
      wr_r <= cpu_wr_i;
      cpu_mio_i_l <= cpu_mio_i;
    end
  end

  // Per-access timing latched once the open row is known
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      len_r <= 6'h00;
      cas_at_r <= 6'h00;
      col_at_r <= 4'h0;
      bank_r <= 2'h0;
      row_r <= '0;
      col_r <= 10'h000;
      wp_r <= 1'b0;
      hit_r <= 1'b0;
      last_hit_r <= 1'b0;
    end else if (st_r == ST_DEC) begin
      len_r <= rom_len;
    end else if (st_r == ST_TAG) begin
      len_r <= acc_len;
      cas_at_r <= (cas_w < acc_len) ? cas_w : 6'h00;
      col_at_r <= {1'b0, cas_cfg_r[F_RCOL +: 3]};
      bank_r <= bank_w;
      row_r <= row_w;
      col_r <= phys[10:1];
      wp_r <= in_sh & shwp_r[seg] & wr_r;
      hit_r <= hit_w;
      last_hit_r <= hit_w;
    end
  end

  // Open-row bits: refresh clears all, precharge clears the bank, a miss access sets it
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) open_r <= 4'h0;
    else if (st_r == ST_REF) open_r <= 4'h0;
    else if (st_r == ST_PRE) open_r[bank_r] <= 1'b0;
    else if (st_r == ST_ACC && !hit_r && cnt_r == 6'h00) open_r[bank_r] <= 1'b1;
  end

  pidc_tag_mem u_tag (
    .core_clk_i (core_clk_i),
    .wr_en_i    (st_r == ST_PRE && cnt_r == pre_end),
    .wr_addr_i  (bank_r),
    .wr_data_i  (row_r),
    .rd_addr_i  (bank_w),
    .rd_data_o  (tag_q)
  );

  // Refresh: every bank strobed, later banks offset when staggering
  genvar b;
  generate
    for (b = 0; b < BANKS; b++) begin : g_ref
      localparam logic [5:0] OFS = 6'(b * STAG_CLKS);
      wire [5:0] on_at = {3'h0, pre_clk} + (stag ? OFS : 6'h00);
      always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) ref_ras_r[b] <= 1'b0;
        else ref_ras_r[b] <= (st_r == ST_REF) && (cnt_r >= on_at) &&
                             (cnt_r < on_at + 6'(REF_RAS_CLKS));
      end
    end
  endgenerate

  // Row/column switch; odd half-clock settings on a miss use the falling-edge copy
  wire pos_sel = (st_r == ST_ACC) && (hit_r || cnt_r >= {2'h0, col_at_r[3:1]});
  always_ff @(negedge core_clk_i) begin
    if (!reset_n_i) neg_sel_r <= 1'b0;
    else neg_sel_r <= pos_sel;
  end
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) ma_col_r <= 1'b0;
    else ma_col_r <= col_at_r[0] & ~hit_r;
  end
  wire col_sel = ma_col_r ? neg_sel_r : pos_sel;
  assign dram_ma_o = col_sel ? {1'b0, col_r} : row_r[10:0];

  wire cas_on = (st_r == ST_ACC) && (cnt_r >= cas_at_r) && !wp_r;
  assign cas_n_o     = ~({4{cas_on}} & (4'h1 << bank_r));
  assign ras_n_o     = ~(open_r | ref_ras_r);
  assign dram_we_n_o = ~wr_r;
  assign rom_cs_n_o  = ~(st_r == ST_ROM);
  assign sysbus_fwd_o = (st_r == ST_BUS);

  // Ready ends every cycle kind; next address one clock early in pipelined mode
  assign cpu_rdy_o = ((st_r == ST_ACC || st_r == ST_ROM) && last) ||
                     (st_r == ST_BUS && bus_rdy) || (st_r == ST_IO);
  assign cpu_na_o  = pipe && (st_r == ST_ACC || st_r == ST_ROM) &&
                     (cnt_r == len_r - 6'h2);

  // Port 92: A20 gate level and a timed reset pulse on a 0-to-1 write
  wire p92_wr = (st_r == ST_IO) && wr_r;
  logic p92_rst_r;
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      p92_a20_r <= 1'b0;
      p92_rst_r <= 1'b0;
      rst_cnt_r <= 8'h00;
      cpu_iodata_o <= 8'h00;
    end else begin
      if (p92_wr) begin
        p92_a20_r <= cpu_wdata_i[P92_A20];
        p92_rst_r <= cpu_wdata_i[P92_RST];
      end
      if (p92_wr && cpu_wdata_i[P92_RST] && !p92_rst_r) rst_cnt_r <= 8'(RST_CLKS);
      else if (rst_cnt_r != 8'h00) rst_cnt_r <= rst_cnt_r - 8'h01;
      cpu_iodata_o <= (st_r == ST_IO && !wr_r) ? {6'h00, p92_a20_r, p92_rst_r} : 8'h00;
    end
  end
  assign cpu_reset_o = (rst_cnt_r != 8'h00);
  assign address_bit20_gate_o = a20_en;

  // Register port
  wire [31:0] stat_w = {19'h0, st_r, open_r[2:0] & 3'h0, open_r[3] & 1'b0} |
                       {20'h0, open_r, 5'h0, last_hit_r, a20_en, cpu_reset_o};
  logic [31:0] rd_mux;
  always_comb begin
    unique case (reg_addr_i)
      REG_CFG:   rd_mux = cfg_r;
      REG_CAS:   rd_mux = cas_cfg_r;
      REG_ROMWS: rd_mux = romws_r;
      REG_ROMLO: rd_mux = romlo_r;
      REG_ROMHI: rd_mux = romhi_r;
      REG_SHEN:  rd_mux = shen_r;
      REG_SHWP:  rd_mux = shwp_r;
      REG_MAP:   rd_mux = map_r;
      REG_STAT:  rd_mux = {20'h0, open_r, 5'h0, last_hit_r, a20_en, cpu_reset_o};
      default:   rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      cfg_r <= CFG_RST;
      cas_cfg_r <= CAS_RST;
      romws_r <= ROMWS_RST;
      romlo_r <= ROMLO_RST;
      romhi_r <= ROMHI_RST;
      shen_r <= 32'h00000000;
      shwp_r <= 32'h00000000;
      map_r <= 32'h00000000;
      reg_rdata_o <= 32'h00000000;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_mux : 32'h00000000;
      if (reg_wr_i) begin
        unique case (reg_addr_i)
          REG_CFG:   cfg_r <= {21'h0, reg_wdata_i[10:0]};
          REG_CAS:   cas_cfg_r <= {23'h0, reg_wdata_i[8:0]};
          REG_ROMWS: romws_r <= {28'h0, reg_wdata_i[3:0]};
          REG_ROMLO: romlo_r <= {22'h0, reg_wdata_i[9:0]};
          REG_ROMHI: romhi_r <= {22'h0, reg_wdata_i[9:0]};
          REG_SHEN:  shen_r <= {8'h0, reg_wdata_i[23:0]};
          REG_SHWP:  shwp_r <= {8'h0, reg_wdata_i[23:0]};
          REG_MAP:   map_r <= {24'h0, reg_wdata_i[7:0]};
          default:   ;
        endcase
      end
    end
  end
  wire unused_stat = &stat_w;
endmodule : pidc_ctrl

// ==== src/pidc_pkg.sv ====
// Package: constants, register map, field layout and state codes of the page interleave DRAM controller.
// Assumes one 200 MHz double-frequency clock drives the whole controller.
package pidc_pkg;
  localparam int unsigned CLK_MHZ      = 200;
  localparam int unsigned T_CLKS       = 2;     // Double-frequency clocks per processor state
  localparam int unsigned REF_RAS_NS   = 100;
  localparam int unsigned REF_RAS_CLKS = (REF_RAS_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned STAG_NS      = 10;
  localparam int unsigned STAG_CLKS    = (STAG_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RST_NS       = 100;
  localparam int unsigned RST_CLKS     = (RST_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned BANKS        = 4;
  localparam int unsigned ROW_W        = 12;

  // Register word indices
  localparam logic [3:0] REG_CFG   = 4'h0;
  localparam logic [3:0] REG_CAS   = 4'h1;
  localparam logic [3:0] REG_ROMWS = 4'h2;
  localparam logic [3:0] REG_ROMLO = 4'h3;
  localparam logic [3:0] REG_ROMHI = 4'h4;
  localparam logic [3:0] REG_SHEN  = 4'h5;
  localparam logic [3:0] REG_SHWP  = 4'h6;
  localparam logic [3:0] REG_MAP   = 4'h7;
  localparam logic [3:0] REG_STAT  = 4'h8;

  // Field positions
  localparam int unsigned F_HIT  = 0;   // 2 bits, 0..3 wait states
  localparam int unsigned F_MISS = 2;   // 2 bits, code+1 wait states
  localparam int unsigned F_WRL  = 4;   // Write miss one less
  localparam int unsigned F_PRE  = 5;   // 2 bits, code+2 clocks
  localparam int unsigned F_ILV  = 7;   // 2 bits: off, two-way, four-way
  localparam int unsigned F_PIPE = 9;
  localparam int unsigned F_STAG = 10;
  localparam int unsigned F_CH   = 0;   // 2 bits each, CAS start per cycle kind
  localparam int unsigned F_CR   = 2;
  localparam int unsigned F_CW   = 4;
  localparam int unsigned F_RCOL = 6;   // 3 bits, half-clock steps
  localparam int unsigned F_DIS  = 0;   // 5 bits, one per 128K block
  localparam int unsigned F_RMAP = 5;   // 3 bits
  localparam int unsigned P92_RST = 0;
  localparam int unsigned P92_A20 = 1;

  localparam logic [31:0] CFG_RST   = 32'h0000006F;
  localparam logic [31:0] CAS_RST   = 32'h000001FF;
  localparam logic [31:0] ROMWS_RST = 32'h0000000A;
  localparam logic [31:0] ROMLO_RST = 32'h0000003C;
  localparam logic [31:0] ROMHI_RST = 32'h0000003F;

  localparam logic [3:0]  ROM_WS_MIN = 4'h1;
  localparam logic [3:0]  ROM_WS_MAX = 4'hA;
  localparam logic [2:0]  RMAP_SPLIT = 3'h1;
  localparam logic [2:0]  RMAP_FULL  = 3'h7;
  localparam logic [1:0]  ILV_TWO    = 2'h1;
  localparam logic [1:0]  ILV_FOUR   = 2'h2;
  localparam logic [23:0] SH_BASE    = 24'h0A0000;
  localparam logic [23:0] SPLIT_BASE = 24'h080000;
  localparam logic [23:0] ONE_MEG    = 24'h100000;
  localparam logic [23:0] DRAM_TOP   = 24'h800000;
  localparam logic [22:0] P92_WADR   = 23'h000049;
  localparam int unsigned SEG_SH     = 14;  // 16K segment
  localparam int unsigned BLK_SH     = 17;  // 128K block

  function automatic logic [23:0] remap_size(input logic [2:0] code);
    unique case (code)
      3'h0: remap_size = 24'h000000;
      3'h1: remap_size = 24'h080000;
      3'h2: remap_size = 24'h020000;
      3'h3: remap_size = 24'h040000;
      3'h4: remap_size = 24'h048000;
      3'h5: remap_size = 24'h050000;
      3'h6: remap_size = 24'h058000;
      3'h7: remap_size = 24'h060000;
    endcase
  endfunction : remap_size

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001, ST_DEC = 9'h002, ST_TAG = 9'h004, ST_PRE = 9'h008, ST_ACC = 9'h010,
    ST_ROM  = 9'h020, ST_BUS = 9'h040, ST_IO  = 9'h080, ST_REF = 9'h100
  } pidc_state_t;
endpackage : pidc_pkg

// ==== src/pidc_tag_mem.sv ====
// Open-row store: one row number per DRAM bank, registered read.
// Assumes the caller keeps the per-bank valid bits itself.
`timescale 1ns/1ps
module pidc_tag_mem import pidc_pkg::*; (
  input  wire logic             core_clk_i,
  input  wire logic             wr_en_i,
  input  wire logic [1:0]       wr_addr_i,
  input  wire logic [ROW_W-1:0] wr_data_i,
  input  wire logic [1:0]       rd_addr_i,
  output logic      [ROW_W-1:0] rd_data_o
);
  logic [ROW_W-1:0] mem_r [BANKS];

  always_ff @(posedge core_clk_i) begin
    if (wr_en_i) begin
      mem_r[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem_r[rd_addr_i];
  end
endmodule : pidc_tag_mem

// ==== test/pidc_ctrl_assertions.sv ====
// Checker: timing relations between the controller's pins.
// Assumes it is bound into pidc_ctrl and sees only its ports.
`timescale 1ns/1ps
module pidc_chk import pidc_pkg::*; (
  input wire logic       core_clk_i,
  input wire logic       reset_n_i,
  input wire logic       a20_kbd_i,
  input wire logic       cpu_rdy_o,
  input wire logic       cpu_na_o,
  input wire logic       cpu_reset_o,
  input wire logic       address_bit20_gate_o,
  input wire logic       sysbus_fwd_o,
  input wire logic       rom_cs_n_o,
  input wire logic [3:0] ras_n_o,
  input wire logic [3:0] cas_n_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  logic [7:0] rst_cnt_r;
  logic       clean_r;
  // Only pulses that start after a low phase are measured
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i || !cpu_reset_o) rst_cnt_r <= 8'h00;
    else rst_cnt_r <= rst_cnt_r + 8'h01;
    clean_r <= reset_n_i & (clean_r | ~cpu_reset_o);
  end
  chk_na_then_rdy: assert property (cpu_na_o |=> cpu_rdy_o)
    else $error("next address not followed by ready");
  chk_rdy_single: assert property (cpu_rdy_o |=> !cpu_rdy_o)
    else $error("ready longer than one cycle");
  chk_rom_no_cas: assert property (!rom_cs_n_o |-> &cas_n_o)
    else $error("CAS active during ROM cycle");
  chk_fwd_no_cas: assert property (sysbus_fwd_o |-> &cas_n_o)
    else $error("CAS active during forwarded cycle");
  chk_rom_not_fwd: assert property (!rom_cs_n_o |-> !sysbus_fwd_o)
    else $error("ROM select while forwarding");
  chk_reset_pulse: assert property ($fell(cpu_reset_o) && clean_r |-> rst_cnt_r == RST_CLKS)
    else $error("processor reset pulse length wrong");
  chk_gate_kbd: assert property (a20_kbd_i [*4] |-> address_bit20_gate_o)
    else $error("gate not following keyboard pin");
  chk_pre_bank0: assert property ($rose(ras_n_o[0]) |-> ras_n_o[0] [*2])
    else $error("bank 0 precharge too short");
  chk_pre_bank3: assert property ($rose(ras_n_o[3]) |-> ras_n_o[3] [*2])
    else $error("bank 3 precharge too short");
  chk_cas_in_ras: assert property (&(cas_n_o | ~ras_n_o))
    else $error("CAS without RAS on a bank");
  cov_rom: cover property (!rom_cs_n_o);
  cov_fwd: cover property (sysbus_fwd_o);
  cov_pipe: cover property (cpu_na_o ##1 cpu_rdy_o);
endmodule : pidc_chk

bind pidc_ctrl pidc_chk chk_u (.core_clk_i, .reset_n_i, .a20_kbd_i, .cpu_rdy_o, .cpu_na_o, .cpu_reset_o,
  .address_bit20_gate_o, .sysbus_fwd_o, .rom_cs_n_o, .ras_n_o, .cas_n_o);

// ==== test/pidc_sysbus_model.sv ====
// Expansion bus model: answers a forwarded cycle after DELAY clocks.
// Assumes the controller holds its forward request until it sees ready.
`timescale 1ns/1ps
module pidc_sysbus_model #(
  parameter int DELAY = 3
) (
  input  wire logic core_clk_i,
  input  wire logic reset_n_i,
  input  wire logic sysbus_fwd_i,
  output logic      sysbus_rdy_o
);
  int cnt_r;
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i || !sysbus_fwd_i) cnt_r <= 0;
    else if (cnt_r < DELAY) cnt_r <= cnt_r + 1;
  end
  // Gated by the request so a released bus never shows a stale ready
  assign sysbus_rdy_o = sysbus_fwd_i && (cnt_r >= DELAY);
endmodule : pidc_sysbus_model

// ==== test/tb.sv ====
// Bench: register, DRAM, ROM, shadow, remap, port 92 and refresh sequences.
// Assumes one 200 MHz clock and the bus model answering forwarded cycles.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin errors++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module tb;
  import pidc_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        reset_n_i, reg_wr_i, reg_rd_i, cpu_ads_i, cpu_wr_i, cpu_mio_i, a20_kbd_i, refresh_req_i;
  logic        sysbus_rdy_i, cpu_rdy_o, cpu_na_o, cpu_reset_o, address_bit20_gate_o, sysbus_fwd_o;
  logic        rom_cs_n_o, cs, rs, fs, ns, up;
  logic [3:0]  reg_addr_i, ras_n_o, cas_n_o;
  logic [31:0] reg_wdata_i, reg_rdata_o, rd;
  logic [23:1] cpu_adr_i;
  logic [7:0]  cpu_wdata_i, cpu_iodata_o, iod;
  int          errors = 0, n_tests = 0, lat, t0, t1, rst_cnt, ws;
  logic [23:0] sz [8] = '{24'h000000, 24'h080000, 24'h020000, 24'h040000, 24'h048000, 24'h050000,
                          24'h058000, 24'h060000};
  logic [31:0] rv [8] = '{CFG_RST, CAS_RST, ROMWS_RST, ROMLO_RST, ROMHI_RST, 32'h0, 32'h0, 32'h0};
  int          rws [4] = '{0, 1, 10, 15};

  pidc_ctrl dut_u (.core_clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .cpu_ads_i, .cpu_adr_i, .cpu_wr_i, .cpu_mio_i, .cpu_wdata_i, .cpu_rdy_o, .cpu_na_o, .cpu_iodata_o,
    .cpu_reset_o, .a20_kbd_i, .address_bit20_gate_o, .refresh_req_i, .sysbus_rdy_i, .sysbus_fwd_o,
    .rom_cs_n_o, .ras_n_o, .cas_n_o, .dram_ma_o(), .dram_we_n_o());
  pidc_sysbus_model bus_u (.core_clk_i, .reset_n_i, .sysbus_fwd_i(sysbus_fwd_o), .sysbus_rdy_o(sysbus_rdy_i));

  always #2.5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) if (cpu_reset_o === 1'b1) rst_cnt++;

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  task automatic reg_w(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask : reg_w

  task automatic reg_r(input logic [3:0] a);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 rd = reg_rdata_o;
  endtask : reg_r

  // Latency is the cycle index of ready, the strobe cycle being zero
  task automatic cyc(input logic [23:0] a, input logic w, input logic m, input logic [7:0] d);
    @(posedge core_clk_i);
    cpu_ads_i <= 1'b1;
    cpu_adr_i <= a[23:1];
    cpu_wr_i <= w;
    cpu_mio_i <= m;
    cpu_wdata_i <= d;
    @(posedge core_clk_i);
    cpu_ads_i <= 1'b0;
    {cs, rs, fs, ns} = 4'h0;
    for (lat = 1; lat < 300; lat++) begin
      #1;
      {cs, rs, fs, ns} = {cs | ~&cas_n_o, rs | ~rom_cs_n_o, fs | sysbus_fwd_o, ns | cpu_na_o};
      if (cpu_rdy_o === 1'b1) break;
      @(posedge core_clk_i);
    end
    if (lat >= 300) begin
      errors++;
      print_verdict();
    end
    @(posedge core_clk_i);
    #1 iod = cpu_iodata_o;
  endtask : cyc

  initial begin
    {reset_n_i, reg_wr_i, reg_rd_i, cpu_ads_i, cpu_wr_i, cpu_mio_i, a20_kbd_i, refresh_req_i} = 8'h00;
    {reg_addr_i, reg_wdata_i, cpu_adr_i, cpu_wdata_i} = 67'h0;
    repeat (5) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      reg_r(4'(i));
      `CHK("reset value", rv[i], rd)
    end
    reg_w(4'h9, 32'hFFFFFFFF);
    reg_r(4'h9);
    `CHK("unmapped", 32'h0, rd)
    reg_w(REG_CFG, 32'hFFFFFFFF);
    reg_r(REG_CFG);
    `CHK("cfg fields", 32'h000007FF, rd)
    $display("test registers done");
    for (int h = 0; h < 4; h++) begin
      reg_w(REG_CFG, 32'(h));
      cyc(24'h000000, 1'b0, 1'b1, 8'h00);
      cyc(24'h000000, 1'b0, 1'b1, 8'h00);
      `CHK("hit latency", 2 + 2 * (2 + h), lat)
      `CHK("hit cas", 1'b1, cs)
    end
    $display("test page hit done");
    // Alternating rows in one bank force a miss on every access
    for (int m = 0; m < 4; m++) for (int p = 0; p < 4; p++) begin
      reg_w(REG_CFG, 32'((m << F_MISS) | (p << F_PRE)));
      cyc(24'h040000, 1'b0, 1'b1, 8'h00);
      cyc(24'h000000, 1'b0, 1'b1, 8'h00);
      `CHK("miss latency", 2 + (p + 2) + 2 * (3 + m), lat)
    end
    for (int m = 0; m < 4; m++) begin
      reg_w(REG_CFG, 32'((m << F_MISS) | (1 << F_WRL)));
      cyc(24'h040000, 1'b1, 1'b1, 8'h00);
      cyc(24'h000000, 1'b1, 1'b1, 8'h00);
      ws = (m == 0) ? 1 : m;
      `CHK("write miss latency", 4 + 2 * (2 + ws), lat)
    end
    $display("test page miss done");
    reg_w(REG_SHEN, 32'h3);
    reg_w(REG_SHWP, 32'h1);
    cyc(24'h0A0000, 1'b1, 1'b1, 8'h00);
    `CHK("protected write cas", 1'b0, cs)
    cyc(24'h0A4000, 1'b1, 1'b1, 8'h00);
    `CHK("open write cas", 1'b1, cs)
    cyc(24'h0A0000, 1'b0, 1'b1, 8'h00);
    `CHK("shadow read cas", 1'b1, cs)
    for (int c = 0; c < 8; c++) begin
      reg_w(REG_MAP, 32'(c << F_RMAP));
      if (c == 7) cyc(24'h0A4000, 1'b0, 1'b1, 8'h00);
      if (c == 7) `CHK("full remap shadow", 1'b0, cs)
      if (c > 0) cyc(DRAM_TOP + sz[c] - 24'h2, 1'b0, 1'b1, 8'h00);
      if (c > 0) `CHK("remap inside", 1'b1, cs)
      cyc(DRAM_TOP + sz[c], 1'b0, 1'b1, 8'h00);
      `CHK("remap outside", 1'b0, cs)
    end
    reg_w(REG_SHEN, 32'h0);
    $display("test shadow and remap done");
    for (int b = 0; b < 5; b++) begin
      reg_w(REG_MAP, 32'(1 << b));
      cyc(24'(b) * 24'h020000 + 24'h100, b[0], 1'b1, 8'h00);
      `CHK("disabled forward", 1'b1, fs)
      `CHK("disabled cas", 1'b0, cs)
      cyc(24'((b + 1) % 5) * 24'h020000 + 24'h100, 1'b0, 1'b1, 8'h00);
      `CHK("enabled cas", 1'b1, cs)
    end
    reg_w(REG_MAP, 32'h0);
    $display("test disable done");
    for (int i = 0; i < 4; i++) begin
      reg_w(REG_ROMWS, 32'(rws[i]));
      ws = (rws[i] < 1) ? 1 : (rws[i] > 10) ? 10 : rws[i];
      cyc(24'h0F0000, 1'b0, 1'b1, 8'h00);
      `CHK("rom select", 1'b1, rs)
      `CHK("rom latency", 1 + 2 * (2 + ws), lat)
    end
    reg_w(REG_ROMLO, 32'h3D);
    cyc(24'h0F0000, 1'b0, 1'b1, 8'h00);
    `CHK("rom below range", 1'b0, rs)
    cyc(24'h0F4000, 1'b0, 1'b1, 8'h00);
    `CHK("rom low bound", 1'b1, rs)
    $display("test rom done");
    for (int pp = 1; pp >= 0; pp--) begin
      reg_w(REG_CFG, 32'(pp << F_PIPE));
      cyc(24'h000000, 1'b0, 1'b1, 8'h00);
      cyc(24'h000000, 1'b0, 1'b1, 8'h00);
      `CHK("next address", 1'(pp), ns)
    end
    $display("test pipeline done");
    cyc(24'h000092, 1'b1, 1'b0, 8'h02);
    `CHK("io latency", 2, lat)
    `CHK("gate on", 1'b1, address_bit20_gate_o)
    cyc(24'h000092, 1'b0, 1'b0, 8'h00);
    `CHK("port read", 8'h02, iod)
    rst_cnt = 0;
    cyc(24'h000092, 1'b1, 1'b0, 8'h03);
    repeat (40) @(posedge core_clk_i);
    `CHK("reset pulse", RST_CLKS, rst_cnt)
    cyc(24'h000092, 1'b0, 1'b0, 8'h00);
    `CHK("port read", 8'h03, iod)
    cyc(24'h000092, 1'b1, 1'b0, 8'h00);
    `CHK("gate off", 1'b0, address_bit20_gate_o)
    a20_kbd_i <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    #1 `CHK("gate from pin", 1'b1, address_bit20_gate_o)
    a20_kbd_i <= 1'b0;
    $display("test port 92 done");
    for (int s = 0; s < 2; s++) begin
      reg_w(REG_CFG, 32'(s << F_STAG));
      {t0, t1, up} = {-32'sd1, -32'sd1, 1'b0};
      refresh_req_i <= 1'b1;
      for (int k = 0; k < 100; k++) begin
        @(posedge core_clk_i);
        #1 up = up | &ras_n_o;
        if (up && ras_n_o[0] === 1'b0 && t0 < 0) t0 = k;
        if (up && ras_n_o[1] === 1'b0 && t1 < 0) t1 = k;
        if (t0 >= 0) refresh_req_i <= 1'b0;
      end
      `CHK("stagger offset", s * int'(STAG_CLKS), t1 - t0)
    end
    $display("test refresh done");
    print_verdict();
  end
endmodule : tb
